// [shared/uie_pkg.sv]
/*
 * uie_pkg: register map, field positions, reset values and identification
 * codes of the per-channel interrupt enable / identify block.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package uie_pkg;

	// register byte addresses
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h00;
	localparam logic [7:0] ADDR_IRQ_IDENT  = 8'h04;
	localparam logic [7:0] ADDR_PENDING    = 8'h08;

	// enable register bit positions
	localparam int EN_RX_DATA = 0;
	localparam int EN_TX_HOLD = 1;
	localparam int EN_LINE    = 2;
	localparam int EN_MODEM   = 3;
	localparam int EN_SLEEP   = 4;
	localparam int EN_XOFF    = 5;
	localparam int EN_RTS     = 6;
	localparam int EN_CTS     = 7;

	localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;

	// identification codes for bits 3:0
	localparam logic [3:0] ID_LINE    = 4'h6;
	localparam logic [3:0] ID_TIMEOUT = 4'hC;
	localparam logic [3:0] ID_RX_DATA = 4'h4;
	localparam logic [3:0] ID_TX_HOLD = 4'h2;
	localparam logic [3:0] ID_MODEM   = 4'h0;
	localparam logic [3:0] ID_NONE    = 4'h1;

	// identification register bit positions
	localparam int ID_XOFF_BIT   = 4;
	localparam int ID_FLOW_BIT   = 5;

	// source currently reported, in priority order
	typedef enum logic [2:0] {
		SRC_NONE    = 3'b000,
		SRC_LINE    = 3'b001,
		SRC_TIMEOUT = 3'b010,
		SRC_RX_DATA = 3'b011,
		SRC_TX_HOLD = 3'b100,
		SRC_MODEM   = 3'b101,
		SRC_XOFF    = 3'b110,
		SRC_FLOW    = 3'b111
	} uie_src_t;

endpackage : uie_pkg

// [verilog/uie_irq_ident.sv]
/*
 * uie_irq_ident: interrupt enable register, prioritised identification
 * register and interrupt output of one UART channel, as a Wishbone slave.
 * Assumes source conditions come from the channel's FIFO, line and modem
 * logic as levels or one-cycle pulses on mclk, and that the enhanced
 * feature write enable, FIFO enable and interrupt output enable bits are
 * supplied by their owning registers outside.
 */
`timescale 1ns/1ps

// Operation
// [R1] six enableable sources: line error, rx, tx space, xoff, cts/rts, modem
// [R2] interrupt output asserts while any enabled source is pending
// [R3] enable bits 7,6,5 gate cts, rts and xoff; reset to zero
// [R4] enable bit 4 selects sleep mode; resets to zero
// [R5] enable bit 3 gates modem status interrupt; resets to zero
// [R6] enable bit 2 gates line status error interrupt; resets to zero
// [R7] enable bit 1 gates transmit holding interrupt; resets to zero
// [R8] enable bit 0 gates receive holding interrupt; resets to zero
// [R9] writes to enable bits 7:4 ignored unless enhanced write enable set
// [R10] re-enabling transmit interrupt raises nothing new below threshold
// [R11] identification register is 8-bit, read-only, priority-encoded
// [R12] identification bits 7 and 6 mirror the fifo enable bit
// [R13] identification bit 5 set on cts/rts low-to-high change
// [R14] identification bit 4 set on xoff or special character detect
// [R15] identification bit 0 is zero when pending, one when idle
// [R16] codes: line 0110, timeout 1100, rx 0100, tx 0010, modem 0000
// [R17] xoff priority 5 as bit 4; cts/rts priority 6 as bit 5
// [R18] interrupt output tri-stated when output control bit clear
// [R19] special character match sets identification bit 4
// [R20] modem change flags clear outside on modem status read
// [R21] report only highest pending source until serviced, then next
// [R22] reading identification while tx reported clears tx interrupt
module uie_irq_ident (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// control bits owned elsewhere
	input  wire logic        enh_write_en,
	input  wire logic        fifo_enable,
	input  wire logic        irq_out_enable,
	// interrupt sources
	input  wire logic        line_error,
	input  wire logic        rx_timeout,
	input  wire logic        rx_data_ready,
	input  wire logic        tx_level_cross,
	input  wire logic        modem_change,
	input  wire logic        xoff_detect,
	input  wire logic        special_detect,
	input  wire logic        cts_rise,
	input  wire logic        rts_rise,
	// outputs
	output logic             sleep_mode,
	output logic             irq_o,
	output logic             irq_oe
);

	typedef struct packed {
		logic [7:0]  irq_en;
		logic        tx_pend;
		logic        xoff_pend;
		logic        cts_pend;
		logic        rts_pend;
		logic        irq;
		logic        ack;
		logic [31:0] rdata;
	} uie_state_t;

	uie_state_t          st_reg;
	uie_state_t          st_next;
	uie_pkg::uie_src_t   src;
	logic [7:0]          ident_val;
	logic [6:0]          pend_vec;
	logic                any_pend;
	logic                req;
	logic                en_write;
	logic                rd_ident;

	assign req       = wb_cyc_i & wb_stb_i & ~st_reg.ack;
	assign en_write  = req & wb_we_i & wb_sel_i[0]
		& (wb_adr_i == uie_pkg::ADDR_IRQ_ENABLE);
	assign rd_ident  = req & ~wb_we_i & (wb_adr_i == uie_pkg::ADDR_IRQ_IDENT);

	// gated sources, bit order follows priority
	always_comb begin
		pend_vec[0] = line_error     & st_reg.irq_en[uie_pkg::EN_LINE];    // R6 R1
		pend_vec[1] = rx_timeout     & st_reg.irq_en[uie_pkg::EN_RX_DATA]; // R8
		pend_vec[2] = rx_data_ready  & st_reg.irq_en[uie_pkg::EN_RX_DATA]; // R8
		pend_vec[3] = st_reg.tx_pend & st_reg.irq_en[uie_pkg::EN_TX_HOLD]; // R7
		// flags clear outside when the modem status is read
		pend_vec[4] = modem_change   & st_reg.irq_en[uie_pkg::EN_MODEM];   // R5 R20
		pend_vec[5] = st_reg.xoff_pend & st_reg.irq_en[uie_pkg::EN_XOFF];  // R3
		pend_vec[6] = (st_reg.cts_pend & st_reg.irq_en[uie_pkg::EN_CTS])
			| (st_reg.rts_pend & st_reg.irq_en[uie_pkg::EN_RTS]);       // R3
	end

	assign any_pend = |pend_vec;

	// priority encoder; lower index wins
	always_comb begin
		if (pend_vec[0]) begin                       // R21
			src = uie_pkg::SRC_LINE;
		end else if (pend_vec[1]) begin
			src = uie_pkg::SRC_TIMEOUT;
		end else if (pend_vec[2]) begin
			src = uie_pkg::SRC_RX_DATA;
		end else if (pend_vec[3]) begin
			src = uie_pkg::SRC_TX_HOLD;
		end else if (pend_vec[4]) begin
			src = uie_pkg::SRC_MODEM;
		end else if (pend_vec[5]) begin
			src = uie_pkg::SRC_XOFF;
		end else if (pend_vec[6]) begin
			src = uie_pkg::SRC_FLOW;
		end else begin
			src = uie_pkg::SRC_NONE;
		end
	end

	always_comb begin
		ident_val = {{2{fifo_enable}}, 2'b00, uie_pkg::ID_NONE}; // R12 R11
		case (src)
			uie_pkg::SRC_LINE: begin
				ident_val[3:0] = uie_pkg::ID_LINE;    // R16
			end
			uie_pkg::SRC_TIMEOUT: begin
				ident_val[3:0] = uie_pkg::ID_TIMEOUT; // R16
			end
			uie_pkg::SRC_RX_DATA: begin
				ident_val[3:0] = uie_pkg::ID_RX_DATA; // R16
			end
			uie_pkg::SRC_TX_HOLD: begin
				ident_val[3:0] = uie_pkg::ID_TX_HOLD; // R16
			end
			uie_pkg::SRC_MODEM: begin
				ident_val[3:0] = uie_pkg::ID_MODEM;   // R16 R15
			end
			uie_pkg::SRC_XOFF: begin
				ident_val[3:0] = uie_pkg::ID_MODEM;   // R17 R15
				ident_val[uie_pkg::ID_XOFF_BIT] = 1'b1; // R14 R19
			end
			uie_pkg::SRC_FLOW: begin
				ident_val[3:0] = uie_pkg::ID_MODEM;   // R17 R15
				ident_val[uie_pkg::ID_FLOW_BIT] = 1'b1; // R13
			end
			uie_pkg::SRC_NONE: begin
				ident_val[3:0] = uie_pkg::ID_NONE;    // R15
			end
			default: begin
				ident_val[3:0] = uie_pkg::ID_NONE;
			end
		endcase
	end

	always_comb begin
		st_next     = st_reg;
		st_next.ack = req;
		// unmapped and write cycles read back zero
		st_next.rdata = 32'h0000_0000;
		if (req & ~wb_we_i) begin
			case (wb_adr_i)
				uie_pkg::ADDR_IRQ_ENABLE: begin
					st_next.rdata = {24'h00_0000, st_reg.irq_en};
				end
				uie_pkg::ADDR_IRQ_IDENT: begin
					st_next.rdata = {24'h00_0000, ident_val}; // R11
				end
				uie_pkg::ADDR_PENDING: begin
					st_next.rdata = {25'h000_0000, pend_vec};
				end
				default: begin
					st_next.rdata = 32'h0000_0000;
				end
			endcase
		end
		if (en_write) begin
			st_next.irq_en[3:0] = wb_dat_i[3:0];        // R5 R6 R7 R8
			if (enh_write_en) begin
				st_next.irq_en[7:4] = wb_dat_i[7:4];    // R9 R3 R4
			end
		end
		// reading the id retires the reported one-shot source
		if (rd_ident) begin
			if (src == uie_pkg::SRC_TX_HOLD) begin
				st_next.tx_pend = 1'b0;                 // R22 R21
			end
			if (src == uie_pkg::SRC_XOFF) begin
				st_next.xoff_pend = 1'b0;               // R21
			end
			if (src == uie_pkg::SRC_FLOW) begin
				st_next.cts_pend = 1'b0;
				st_next.rts_pend = 1'b0;
			end
		end
		// sets come last so a same-cycle event beats the clear;
		// enable writes never touch tx_pend, so no fresh interrupt
		if (tx_level_cross) begin
			st_next.tx_pend = 1'b1;                     // R10
		end
		if (xoff_detect | special_detect) begin
			st_next.xoff_pend = 1'b1;                   // R14 R19
		end
		if (cts_rise) begin
			st_next.cts_pend = 1'b1;                    // R13
		end
		if (rts_rise) begin
			st_next.rts_pend = 1'b1;                    // R13
		end
		st_next.irq = any_pend;                         // R2
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_reg           <= '0;
			st_reg.irq_en    <= uie_pkg::IRQ_ENABLE_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign wb_dat_o   = st_reg.rdata;
	assign wb_ack_o   = st_reg.ack;
	assign sleep_mode = st_reg.irq_en[uie_pkg::EN_SLEEP]; // R4
	// driven low while tri-stated so nothing floats inside
	assign irq_o      = st_reg.irq & irq_out_enable;    // R18 R2
	assign irq_oe     = irq_out_enable;                 // R18

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	property p_ack_single;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_single: assert property (p_ack_single)
		else $error("ack held for more than one cycle");

	property p_en_lock; // R9
		en_write && !enh_write_en
			|=> st_reg.irq_en[7:4] == $past(st_reg.irq_en[7:4]);
	endproperty
	a_en_lock: assert property (p_en_lock) // R9
		else $error("locked enable bits changed");

	property p_en_low_write; // R8
		en_write |=> st_reg.irq_en[3:0] == $past(wb_dat_i[3:0]);
	endproperty
	a_en_low_write: assert property (p_en_low_write) // R8
		else $error("enable low bits not written");

	property p_idle_bit; // R15
		!any_pend |-> ident_val[0] && ident_val[5:1] == 5'h00;
	endproperty
	a_idle_bit: assert property (p_idle_bit) // R15
		else $error("idle code wrong");

	property p_line_first; // R16
		line_error && st_reg.irq_en[uie_pkg::EN_LINE] |-> ident_val[5:0] == 6'h06;
	endproperty
	a_line_first: assert property (p_line_first) // R16
		else $error("line error not top priority");

	property p_mirror; // R12
		ident_val[7:6] == {2{fifo_enable}};
	endproperty
	a_mirror: assert property (p_mirror) // R12
		else $error("fifo enable mirror wrong");

	property p_irq_out; // R2
		any_pend ##1 irq_out_enable |-> irq_o;
	endproperty
	a_irq_out: assert property (p_irq_out) // R2
		else $error("interrupt output missing");

	property p_tx_clear; // R22
		rd_ident && src == uie_pkg::SRC_TX_HOLD && !tx_level_cross
			|=> !st_reg.tx_pend;
	endproperty
	a_tx_clear: assert property (p_tx_clear) // R22
		else $error("tx interrupt not cleared by id read");

	property p_xoff_set; // R14
		xoff_detect || special_detect |=> st_reg.xoff_pend;
	endproperty
	a_xoff_set: assert property (p_xoff_set) // R14
		else $error("xoff event lost");

	property p_ident_read; // R11
		rd_ident |=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(ident_val)};
	endproperty
	a_ident_read: assert property (p_ident_read) // R11
		else $error("id read data wrong");

	property p_flow_code; // R17
		src == uie_pkg::SRC_FLOW |-> ident_val[5:0] == 6'h20;
	endproperty
	a_flow_code: assert property (p_flow_code) // R17
		else $error("cts/rts code wrong");

	property p_high_write; // R3
		en_write && enh_write_en
			|=> st_reg.irq_en[7:4] == $past(wb_dat_i[7:4]);
	endproperty
	a_high_write: assert property (p_high_write) // R3
		else $error("enable high bits not written");

	property p_sleep_write; // R4
		en_write && enh_write_en
			|=> sleep_mode == $past(wb_dat_i[uie_pkg::EN_SLEEP]);
	endproperty
	a_sleep_write: assert property (p_sleep_write) // R4
		else $error("sleep bit not written");

	property p_rx_code; // R16
		rx_data_ready && !rx_timeout && st_reg.irq_en[uie_pkg::EN_RX_DATA]
			&& !(line_error && st_reg.irq_en[uie_pkg::EN_LINE])
			|-> ident_val[5:0] == 6'h04;
	endproperty
	a_rx_code: assert property (p_rx_code) // R16
		else $error("rx data code wrong");

	property p_timeout_code; // R16
		rx_timeout && st_reg.irq_en[uie_pkg::EN_RX_DATA]
			&& !(line_error && st_reg.irq_en[uie_pkg::EN_LINE])
			|-> ident_val[5:0] == 6'h0C;
	endproperty
	a_timeout_code: assert property (p_timeout_code) // R16
		else $error("timeout code wrong");

	property p_xoff_code; // R17
		src == uie_pkg::SRC_XOFF |-> ident_val[5:0] == 6'h10;
	endproperty
	a_xoff_code: assert property (p_xoff_code) // R17
		else $error("xoff code wrong");

	property p_irq_follow; // R2
		irq_o == ($past(any_pend) && irq_out_enable);
	endproperty
	a_irq_follow: assert property (p_irq_follow) // R2
		else $error("interrupt output does not follow pending");

	property p_irq_off; // R18
		!irq_out_enable |-> !irq_o && !irq_oe;
	endproperty
	a_irq_off: assert property (p_irq_off) // R18
		else $error("interrupt driven while output disabled");

	property p_tx_no_fresh; // R10
		en_write && !tx_level_cross && !st_reg.tx_pend |=> !st_reg.tx_pend;
	endproperty
	a_tx_no_fresh: assert property (p_tx_no_fresh) // R10
		else $error("enable write raised a tx interrupt");

	property p_xoff_hold; // R21
		src == uie_pkg::SRC_XOFF && !rd_ident |=> st_reg.xoff_pend;
	endproperty
	a_xoff_hold: assert property (p_xoff_hold) // R21
		else $error("xoff source dropped before service");

	property p_flow_hold; // R21
		src == uie_pkg::SRC_FLOW && !rd_ident
			|=> st_reg.cts_pend || st_reg.rts_pend;
	endproperty
	a_flow_hold: assert property (p_flow_hold) // R21
		else $error("cts/rts source dropped before service");

	property p_flow_set; // R13
		cts_rise || rts_rise |=> st_reg.cts_pend || st_reg.rts_pend;
	endproperty
	a_flow_set: assert property (p_flow_set) // R13
		else $error("cts/rts event lost");

endmodule : uie_irq_ident

// [bench/uie_host.sv]
/* uie_host: classic Wishbone master standing in for the host cpu.
   assumes a slave on mclk that acks every request. */
`timescale 1ns/1ps
module uie_host (
	// clock
	input  wire logic        mclk,
	// wishbone master
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [7:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      dat_o,
	input  wire logic [31:0] dat_i,
	input  wire logic        ack
);
	initial begin
		{cyc, stb, we, adr, sel, dat_o} <= '0;
	end

	// ok stays low when no ack came within the bound
	task automatic access(input logic w, input logic [7:0] a,
		input logic [7:0] wd, output logic [7:0] rd, output logic ok);
		int n;
		@(posedge mclk);
		{cyc, stb, we, adr, sel, dat_o} <= {2'b11, w, a, 4'h1, 24'h0, wd};
		ok = 1'b0;
		for (n = 0; n < 64 && !ok; n++) begin
			@(posedge mclk);
			ok = (ack === 1'b1);
		end
		rd = dat_i[7:0];
		{cyc, stb} <= 2'b00;
		@(posedge mclk);
	endtask : access
endmodule : uie_host

// [bench/uie_irq_ident_tb.sv]
/* uie_irq_ident_tb: self-checking bench of the enable / identify block.
   assumes uie_host drives the register bus; sources come from here. */
`timescale 1ns/1ps
module uie_irq_ident_tb;
	logic        mclk, nrst, cyc, stb, we, ack, enh, fe, ioe, lerr, tmo;
	logic        rxd, txc, mdm, xof, spc, ctr, rtr, slp, irq, oe;
	logic [7:0]  adr, v;
	logic [3:0]  sel, lv;
	logic [31:0] wdat, rdat, seed, r;
	logic [7:0]  ptab [5] = '{8'h02, 8'h10, 8'h10, 8'h20, 8'h20};
	int          n_errors, cmp_count, i;

	uie_irq_ident uie_irq_ident_i (.mclk(mclk), .nrst(nrst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.enh_write_en(enh), .fifo_enable(fe), .irq_out_enable(ioe),
		.line_error(lerr), .rx_timeout(tmo), .rx_data_ready(rxd),
		.tx_level_cross(txc), .modem_change(mdm), .xoff_detect(xof),
		.special_detect(spc), .cts_rise(ctr), .rts_rise(rtr),
		.sleep_mode(slp), .irq_o(irq), .irq_oe(oe));
	uie_host uie_host_i (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we),
		.adr(adr), .sel(sel), .dat_o(wdat), .dat_i(rdat), .ack(ack));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// lv is {modem, rx data, timeout, line}, already gated
	function automatic logic [7:0] exp_id(logic [3:0] l, logic f);
		logic [3:0] c;
		c = l[0] ? uie_pkg::ID_LINE : l[1] ? uie_pkg::ID_TIMEOUT :
			l[2] ? uie_pkg::ID_RX_DATA : l[3] ? uie_pkg::ID_MODEM :
			uie_pkg::ID_NONE;
		return {f, f, 2'b00, c};
	endfunction : exp_id

	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wb(logic w, logic [7:0] a, logic [7:0] wd);
		logic ok;
		uie_host_i.access(w, a, wd, v, ok);
		if (!ok) begin
			n_errors++;
			wrap_up();
		end
	endtask : wb

	task automatic rdc(logic [7:0] a, logic [7:0] exp, string what);
		wb(1'b0, a, 8'h00);
		check(what, v, exp);
	endtask : rdc

	task automatic pulse(int k);
		@(posedge mclk);
		{txc, xof, spc, ctr, rtr} <= 5'h10 >> k;
		@(posedge mclk);
		{txc, xof, spc, ctr, rtr} <= 5'h00;
	endtask : pulse

	initial begin
		seed = 32'h11547462;
		n_errors = 0;
		cmp_count = 0;
		nrst <= 1'b0;
		{enh, fe, ioe, lerr, tmo, rxd, txc, mdm, xof, spc, ctr, rtr} <= 12'h200;
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		rdc(uie_pkg::ADDR_IRQ_ENABLE, 8'h00, "enable");
		wb(1'b1, uie_pkg::ADDR_IRQ_IDENT, 8'hFE);
		rdc(uie_pkg::ADDR_IRQ_IDENT, 8'h01, "ident");
		$display("test reset done");
		wb(1'b1, uie_pkg::ADDR_IRQ_ENABLE, 8'hFF);
		rdc(uie_pkg::ADDR_IRQ_ENABLE, 8'h0F, "enable locked");
		enh <= 1'b1;
		wb(1'b1, uie_pkg::ADDR_IRQ_ENABLE, 8'hFF);
		rdc(uie_pkg::ADDR_IRQ_ENABLE, 8'hFF, "enable open");
		check("sleep", {7'h00, slp}, 8'h01);
		$display("test write lock done");
		nrst <= 1'b0;
		repeat (2) @(posedge mclk);
		check("sleep reset", {7'h00, slp}, 8'h00);
		nrst <= 1'b1;
		rdc(uie_pkg::ADDR_IRQ_ENABLE, 8'h00, "enable reset");
		$display("test mid-run reset done");
		for (i = 0; i < 24; i++) begin
			r = xs();
			wb(1'b1, uie_pkg::ADDR_IRQ_ENABLE, {4'hE, r[3:0]});
			{mdm, rxd, tmo, lerr, fe} <= r[8:4];
			repeat (2) @(posedge mclk);
			lv = r[8:5] & {r[3], r[0], r[0], r[2]};
			check("irq", {7'h00, irq}, {7'h00, |lv});
			rdc(uie_pkg::ADDR_IRQ_IDENT, exp_id(lv, r[4]), "ident");
			rdc(uie_pkg::ADDR_PENDING, {3'h0, lv[3], 1'b0, lv[2:0]}, "pending");
		end
		{mdm, rxd, tmo, lerr, fe} <= 5'h00;
		wb(1'b1, uie_pkg::ADDR_IRQ_ENABLE, 8'hEF);
		$display("test random levels done");
		for (i = 0; i < 5; i++) begin
			pulse(i);
			rdc(uie_pkg::ADDR_IRQ_IDENT, ptab[i], "one-shot");
			rdc(uie_pkg::ADDR_IRQ_IDENT, 8'h01, "serviced");
		end
		wb(1'b1, uie_pkg::ADDR_IRQ_ENABLE, 8'hED);
		wb(1'b1, uie_pkg::ADDR_IRQ_ENABLE, 8'hEF);
		rdc(uie_pkg::ADDR_IRQ_IDENT, 8'h01, "tx re-enable");
		pulse(3);
		pulse(1);
		rdc(uie_pkg::ADDR_IRQ_IDENT, 8'h10, "first");
		rdc(uie_pkg::ADDR_IRQ_IDENT, 8'h20, "next");
		$display("test one-shot done");
		lerr <= 1'b1;
		ioe <= 1'b0;
		repeat (2) @(posedge mclk);
		check("irq off", {6'h00, oe, irq}, 8'h00);
		ioe <= 1'b1;
		repeat (2) @(posedge mclk);
		check("irq on", {6'h00, oe, irq}, 8'h03);
		$display("test output enable done");
		wrap_up();
	end
endmodule : uie_irq_ident_tb
